// >>> verilog/lcsr_regs.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module lcsr_regs #(
  parameter logic [3:0] REVISION_ID = lcsr_pkg::REVISION_DEFAULT, // Arbitrary value
  parameter int         NPORT       = 2
) (
  input  wire logic             CLOCK,
  input  wire logic             RESET_N,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [7:0]       REG_RDATA,
  output logic                  REG_RVALID,
  input  wire logic             SECOND_PORT_SELECT,
  input  wire logic             CRC_ERR_RESET,
  input  wire logic             TMDS_CLK_DETECT,
  input  wire logic [NPORT-1:0] LINK_DETECT,
  input  wire logic [NPORT-1:0] LINK_LOSS,
  input  wire logic [NPORT-1:0] BACKCHAN_CRC_ERR,
  input  wire logic [NPORT-1:0] BIST_ACTIVE,
  input  wire logic [NPORT-1:0] BIST_RESTART,
  input  wire logic             I2C_ADDR_VALID,
  input  wire logic [6:0]       I2C_ADDR,
  output logic                  REMAP_VALID,
  output logic      [NPORT-1:0] REMAP_PORT_HIT,
  output logic      [NPORT-1:0][6:0] REMAP_ADDR,
  input  wire logic [NPORT-1:0] REMOTE_PIN_VALUE,
  input  wire logic [NPORT-1:0] PIN_ZERO_IN,
  output logic      [NPORT-1:0] PIN_ZERO_OUT,
  output logic      [NPORT-1:0] PIN_ZERO_OE,
  output logic      [NPORT-1:0] PIN_ZERO_SENSE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port state

  lcsr_pkg::lcsr_port_cfg_s   cfg_reg   [NPORT];
  lcsr_pkg::lcsr_port_cfg_s   cfg_next  [NPORT];
  lcsr_pkg::lcsr_port_flags_s flags_reg [NPORT];
  lcsr_pkg::lcsr_port_flags_s flags_next[NPORT];
  logic [lcsr_pkg::CRC_W-1:0] crc_count [NPORT];

  logic       sel_port;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       remap_valid_reg;
  logic       remap_valid_next;
  logic [NPORT-1:0]      remap_hit_reg;
  logic [NPORT-1:0]      remap_hit_next;
  logic [NPORT-1:0][6:0] remap_addr_reg;
  logic [NPORT-1:0][6:0] remap_addr_next;

  // Port index chosen by the select control
  assign sel_port = SECOND_PORT_SELECT;

  // True when a register write lands on the given port's copy
  function automatic logic port_write(input logic [7:0] ofs, input int p);
    port_write = REG_WR && (REG_ADDR == ofs) && (sel_port == p[0]);
  endfunction : port_write

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers, one copy per port

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      cfg_next[p] = cfg_reg[p];
      if (port_write(lcsr_pkg::OFS_TARGET, p)) begin
        cfg_next[p].target = REG_WDATA[lcsr_pkg::ADDR_MSB:lcsr_pkg::ADDR_LSB];
      end
      if (port_write(lcsr_pkg::OFS_ALIAS, p)) begin
        cfg_next[p].alias_id = REG_WDATA[lcsr_pkg::ADDR_MSB:lcsr_pkg::ADDR_LSB];
      end
      if (port_write(lcsr_pkg::OFS_PIN0, p)) begin
        cfg_next[p].pin_value = REG_WDATA[lcsr_pkg::PIN_VAL_BIT];
        cfg_next[p].pin_mode  = REG_WDATA[lcsr_pkg::PIN_MODE_MSB:0];
      end
    end
  end

  // Register stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < NPORT; p++) begin
        cfg_reg[p].target    <= lcsr_pkg::RST_TARGET;
        cfg_reg[p].alias_id  <= lcsr_pkg::RST_ALIAS;
        cfg_reg[p].pin_value <= lcsr_pkg::RST_PIN_VAL;
        cfg_reg[p].pin_mode  <= lcsr_pkg::RST_PIN_MODE;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        cfg_reg[p] <= cfg_next[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the same cycle as a clear wins so no event is lost

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      flags_next[p] = flags_reg[p];
      if (CRC_ERR_RESET) begin
        flags_next[p].link_lost = 1'b0;
      end
      if (LINK_LOSS[p]) begin
        flags_next[p].link_lost = 1'b1;
      end
      if (LINK_LOSS[p] || BIST_RESTART[p] || CRC_ERR_RESET) begin
        flags_next[p].bist_err = 1'b0;
      end
      if (BACKCHAN_CRC_ERR[p] && BIST_ACTIVE[p]) begin
        flags_next[p].bist_err = 1'b1;
      end
      if (LINK_LOSS[p] || CRC_ERR_RESET) begin
        flags_next[p].des_err = 1'b0;
      end
      if (BACKCHAN_CRC_ERR[p] && !BIST_ACTIVE[p]) begin
        flags_next[p].des_err = 1'b1;
      end
    end
  end

  // Register stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < NPORT; p++) begin
        flags_reg[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        flags_reg[p] <= flags_next[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error counters and pin drivers, one per port

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    lcsr_err_count #(
      .WIDTH (lcsr_pkg::CRC_W)
    ) u_count (
      .clk   (CLOCK),
      .rst_n (RESET_N),
      .inc   (BACKCHAN_CRC_ERR[g]),
      .clr   (CRC_ERR_RESET),
      .count (crc_count[g])
    );

    lcsr_pin_drive u_pin (
      .clk          (CLOCK),
      .rst_n        (RESET_N),
      .mode         (cfg_reg[g].pin_mode),
      .out_value    (cfg_reg[g].pin_value),
      .remote_value (REMOTE_PIN_VALUE[g]),
      .link_up      (LINK_DETECT[g]),
      .pad_in       (PIN_ZERO_IN[g]),
      .pad_out      (PIN_ZERO_OUT[g]),
      .pad_oe       (PIN_ZERO_OE[g]),
      .sense        (PIN_ZERO_SENSE[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; reads are free of side effects, unmapped offsets return zero

  always_comb begin
    rvalid_next = REG_RD;
    rdata_next  = rdata_reg;
    if (REG_RD) begin
      unique case (REG_ADDR)
        lcsr_pkg::OFS_TARGET: rdata_next = {cfg_reg[sel_port].target, 1'b0};
        lcsr_pkg::OFS_ALIAS:  rdata_next = {cfg_reg[sel_port].alias_id, 1'b0};
        lcsr_pkg::OFS_CRC_LO: rdata_next = crc_count[sel_port][7:0];
        lcsr_pkg::OFS_CRC_HI: rdata_next = crc_count[sel_port][15:8];
        lcsr_pkg::OFS_STATUS: begin
          rdata_next = 8'h00;
          rdata_next[lcsr_pkg::ST_LINK_LOST] = flags_reg[sel_port].link_lost;
          rdata_next[lcsr_pkg::ST_BIST_ERR]  = flags_reg[sel_port].bist_err;
          rdata_next[lcsr_pkg::ST_TMDS]      = TMDS_CLK_DETECT;
          rdata_next[lcsr_pkg::ST_DES_ERR]   = flags_reg[sel_port].des_err;
          rdata_next[lcsr_pkg::ST_LINK_DET]  = LINK_DETECT[sel_port];
        end
        lcsr_pkg::OFS_PIN0: rdata_next = {REVISION_ID, cfg_reg[sel_port].pin_value,
                                          cfg_reg[sel_port].pin_mode};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg  <= lcsr_pkg::RST_RDATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign REG_RDATA  = rdata_reg;
  assign REG_RVALID = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Alias remapping of local transactions; each port is checked on its own

  always_comb begin
    remap_valid_next = I2C_ADDR_VALID;
    remap_hit_next   = '0;
    remap_addr_next  = remap_addr_reg;
    if (I2C_ADDR_VALID) begin
      for (int p = 0; p < NPORT; p++) begin
        remap_hit_next[p]  = lcsr_pkg::lcsr_alias_hit(cfg_reg[p], I2C_ADDR);
        remap_addr_next[p] = remap_hit_next[p] ? cfg_reg[p].target : I2C_ADDR;
      end
    end
  end

  // Register stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      remap_valid_reg <= 1'b0;
      remap_hit_reg   <= '0;
      remap_addr_reg  <= '0;
    end else begin
      remap_valid_reg <= remap_valid_next;
      remap_hit_reg   <= remap_hit_next;
      remap_addr_reg  <= remap_addr_next;
    end
  end

  assign REMAP_VALID    = remap_valid_reg;
  assign REMAP_PORT_HIT = remap_hit_reg;
  assign REMAP_ADDR     = remap_addr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence alias_match_s;
    I2C_ADDR_VALID && cfg_reg[0].alias_id != 7'h00 && cfg_reg[0].target != 7'h00
      && I2C_ADDR == cfg_reg[0].alias_id;
  endsequence

  alias_remap_a: assert property (alias_match_s |=> REMAP_VALID && REMAP_PORT_HIT[0]
      && REMAP_ADDR[0] == $past(cfg_reg[0].target))
    else $error("Alias not remapped");
  zero_disable_a: assert property (I2C_ADDR_VALID
      && (cfg_reg[0].alias_id == 7'h00 || cfg_reg[0].target == 7'h00) |=> !REMAP_PORT_HIT[0])
    else $error("Zero field did not disable");
  alias_reserved_a: assert property (REG_RD && REG_ADDR == lcsr_pkg::OFS_ALIAS
      |=> REG_RVALID && !REG_RDATA[0])
    else $error("Reserved alias bit set");
  port_steer_a: assert property (REG_WR && SECOND_PORT_SELECT && REG_ADDR == lcsr_pkg::OFS_TARGET
      |=> cfg_reg[1].target == $past(REG_WDATA[7:1]) && $stable(cfg_reg[0].target))
    else $error("Write reached wrong port");
  crc_read_a: assert property (REG_RD && REG_ADDR == lcsr_pkg::OFS_CRC_HI && !SECOND_PORT_SELECT
      |=> REG_RDATA == $past(crc_count[0][15:8]))
    else $error("Counter high byte wrong");
  lost_sticky_a: assert property (flags_reg[0].link_lost && !CRC_ERR_RESET
      |=> flags_reg[0].link_lost)
    else $error("Link lost flag dropped");
  lost_set_a: assert property (LINK_LOSS[0] |=> flags_reg[0].link_lost ##0 !flags_reg[0].des_err
      || $past(BACKCHAN_CRC_ERR[0]))
    else $error("Link loss not flagged");
  bist_err_a: assert property (BACKCHAN_CRC_ERR[0] && BIST_ACTIVE[0]
      |=> flags_reg[0].bist_err)
    else $error("Self-test error not flagged");
  bist_clear_a: assert property (BIST_RESTART[0] && !BACKCHAN_CRC_ERR[0] |=> !flags_reg[0].bist_err)
    else $error("Self-test flag not cleared");
  tmds_status_a: assert property (REG_RD && REG_ADDR == lcsr_pkg::OFS_STATUS
      |=> REG_RDATA[lcsr_pkg::ST_TMDS] == $past(TMDS_CLK_DETECT))
    else $error("Clock detect bit wrong");
  des_err_a: assert property (flags_reg[0].des_err && CRC_ERR_RESET && !BACKCHAN_CRC_ERR[0]
      |=> !flags_reg[0].des_err)
    else $error("Normal error flag not cleared");
  link_status_a: assert property (REG_RD && REG_ADDR == lcsr_pkg::OFS_STATUS
      |=> REG_RDATA[lcsr_pkg::ST_LINK_DET] == $past(LINK_DETECT[sel_port]))
    else $error("Link detect bit wrong");
  pin_steer_a: assert property (REG_WR && SECOND_PORT_SELECT && REG_ADDR == lcsr_pkg::OFS_PIN0
      |=> cfg_reg[1].pin_mode == $past(REG_WDATA[2:0]) && $stable(cfg_reg[0].pin_mode))
    else $error("Pin config reached wrong port");
  read_clean_a: assert property (REG_RD && !LINK_LOSS[0] && !CRC_ERR_RESET && !BIST_RESTART[0]
      && flags_reg[0].des_err |=> flags_reg[0].des_err)
    else $error("Read cleared a flag");

endmodule : lcsr_regs

// >>> inc/lcsr_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants and carriers for the link control and status register slice
package lcsr_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] OFS_TARGET  = 8'h07;
  localparam logic [7:0] OFS_ALIAS   = 8'h08;
  localparam logic [7:0] OFS_CRC_LO  = 8'h0A;
  localparam logic [7:0] OFS_CRC_HI  = 8'h0B;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_PIN0    = 8'h0D;

  // Field positions
  localparam int ADDR_MSB      = 7;   // Address fields sit in bits 7:1
  localparam int ADDR_LSB      = 1;
  localparam int ST_LINK_LOST  = 4;
  localparam int ST_BIST_ERR   = 3;
  localparam int ST_TMDS       = 2;
  localparam int ST_DES_ERR    = 1;
  localparam int ST_LINK_DET   = 0;
  localparam int PIN_VAL_BIT   = 3;
  localparam int PIN_MODE_MSB  = 2;
  localparam int REV_LSB       = 4;

  // Reset values
  localparam logic [6:0] RST_TARGET   = 7'h00;
  localparam logic [6:0] RST_ALIAS    = 7'h00;
  localparam logic       RST_PIN_VAL  = 1'b0;
  localparam logic [2:0] RST_PIN_MODE = 3'h0;
  localparam logic [7:0] RST_RDATA    = 8'h00;

  // Arbitrary revision code, not tied to any real part
  localparam logic [3:0] REVISION_DEFAULT = 4'h0;

  // Pin mode encodings; the low two bits alone pick the function and float modes
  localparam logic [1:0] MODE_LO_FUNC     = 2'h0;
  localparam logic [1:0] MODE_LO_HIZ      = 2'h2;
  localparam logic [2:0] MODE_GPIO_OUT    = 3'h1;
  localparam logic [2:0] MODE_GPIO_IN     = 3'h3;
  localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
  localparam logic [2:0] MODE_REMOTE_DEF  = 3'h7;

  // Error counter width
  localparam int CRC_W = 16;

  // Per-port configuration copy
  typedef struct packed {
    logic [6:0] target;
    logic [6:0] alias_id;
    logic       pin_value;
    logic [2:0] pin_mode;
  } lcsr_port_cfg_s;

  // Per-port sticky flags
  typedef struct packed {
    logic link_lost;
    logic bist_err;
    logic des_err;
  } lcsr_port_flags_s;

  // Alias hit: both fields must be non-zero to enable forwarding
  function automatic logic lcsr_alias_hit(input lcsr_port_cfg_s cfg, input logic [6:0] addr);
    lcsr_alias_hit = (cfg.alias_id != 7'h00) && (cfg.target != 7'h00) && (addr == cfg.alias_id);
  endfunction : lcsr_alias_hit

endpackage : lcsr_pkg

// >>> verilog/lcsr_err_count.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Saturating error counter with synchronous clear
module lcsr_err_count #(
  parameter int WIDTH = lcsr_pkg::CRC_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inc,
  input  wire logic             clr,
  output logic      [WIDTH-1:0] count
);

  localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // An error in the clear cycle still counts, so no event is lost
  always_comb begin
    count_next = count_reg;
    if (clr) begin
      count_next = '0;
    end
    if (inc) begin
      if (clr) begin
        count_next = {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (count_reg != MAX) begin
        count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  count_clear_a: assert property (clr && !inc |=> count_reg == '0)
    else $error("Counter not cleared");
  count_sat_a: assert property (count_reg == MAX && inc && !clr |=> count_reg == MAX)
    else $error("Counter wrapped");
  count_step_a: assert property (count_reg != MAX && inc && !clr |=> count_reg == $past(count_reg) + 1'b1)
    else $error("Counter missed an error");

endmodule : lcsr_err_count

// >>> verilog/lcsr_pin_drive.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Pin zero driver for one port, outputs registered
module lcsr_pin_drive (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] mode,
  input  wire logic       out_value,
  input  wire logic       remote_value,
  input  wire logic       link_up,
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            sense
);

  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic sense_reg, sense_next;
  logic hold_reg, hold_next;

  // Mode decode; remote hold keeps the last value seen while the link was up
  always_comb begin
    out_next   = 1'b0;
    oe_next    = 1'b0;
    sense_next = sense_reg;
    hold_next  = link_up ? remote_value : hold_reg;
    if (mode[1:0] == lcsr_pkg::MODE_LO_FUNC || mode == lcsr_pkg::MODE_GPIO_IN) begin
      sense_next = pad_in;
    end else if (mode[1:0] == lcsr_pkg::MODE_LO_HIZ) begin
      oe_next = 1'b0;
    end else if (mode == lcsr_pkg::MODE_GPIO_OUT) begin
      oe_next  = 1'b1;
      out_next = out_value;
    end else if (mode == lcsr_pkg::MODE_REMOTE_HOLD) begin
      oe_next  = 1'b1;
      out_next = link_up ? remote_value : hold_reg;
    end else begin
      oe_next  = 1'b1;
      out_next = link_up ? remote_value : out_value;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      sense_reg <= 1'b0;
      hold_reg  <= 1'b0;
    end else begin
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      sense_reg <= sense_next;
      hold_reg  <= hold_next;
    end
  end

  assign pad_out = out_reg;
  assign pad_oe  = oe_reg;
  assign sense   = sense_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence link_drop_hold_s;
    mode == lcsr_pkg::MODE_REMOTE_HOLD && link_up ##1
      mode == lcsr_pkg::MODE_REMOTE_HOLD && !link_up;
  endsequence

  pin_local_out_a: assert property (mode == lcsr_pkg::MODE_GPIO_OUT |=> pad_oe && pad_out == $past(out_value))
    else $error("Local output not driven");
  pin_float_a: assert property (mode[1:0] == lcsr_pkg::MODE_LO_HIZ |=> !pad_oe)
    else $error("Pin driven while floating");
  pin_hold_a: assert property (link_drop_hold_s |=> pad_oe && pad_out == $past(remote_value, 2))
    else $error("Remote value not held");
  pin_default_a: assert property (mode == lcsr_pkg::MODE_REMOTE_DEF && !link_up |=> pad_out == $past(out_value))
    else $error("Default value not driven");

endmodule : lcsr_pin_drive

// >>> test/lcsr_far_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of both links: cable state, back channel errors, self-test, remote pin
module lcsr_far_model (
  input  wire logic       clk,
  output logic      [1:0] link_det,
  output logic      [1:0] link_loss,
  output logic      [1:0] crc_err,
  output logic      [1:0] bist_on,
  output logic      [1:0] bist_rst,
  output logic      [1:0] rpin
);
  // Both links start down and quiet
  initial {link_det, link_loss, crc_err, bist_on, bist_rst, rpin} = 12'h000;

  // Event tasks change lines off the rising edge and leave two cycles to settle
  task automatic link(input int p, input logic v);
    link_det[p] = v;
    repeat (2) @(negedge clk);
  endtask : link

  task automatic errs(input int p, input int n);
    crc_err[p] = 1'b1;
    repeat (n) @(negedge clk);
    crc_err[p] = 1'b0;
    repeat (2) @(negedge clk);
  endtask : errs

  // A loss event also drops the cable level, as a real unplug would
  task automatic lose(input int p);
    link_loss[p] = 1'b1;
    link_det[p] = 1'b0;
    @(negedge clk);
    link_loss[p] = 1'b0;
    repeat (2) @(negedge clk);
  endtask : lose

  task automatic restart(input int p);
    bist_rst[p] = 1'b1;
    @(negedge clk);
    bist_rst[p] = 1'b0;
    repeat (2) @(negedge clk);
  endtask : restart

  // Level controls kept here so each line has one owner
  task automatic bist(input int p, input logic v);
    bist_on[p] = v;
  endtask : bist

  task automatic remote(input int p, input logic v);
    rpin[p] = v;
  endtask : remote
endmodule : lcsr_far_model

// >>> test/test_lcsr_regs.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Register, remap, status and pin checks through the strobe port
module test_lcsr_regs;
  logic            clock = 1'b0;
  logic            reset_n = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            sel = 1'b0;
  logic            crc_rst = 1'b0;
  logic            tmds = 1'b0;
  logic            avalid = 1'b0;
  logic [6:0]      i2c_addr = 7'h00;
  logic [1:0]      pin_in = 2'h2;
  logic [7:0]      rdata;
  logic            rvalid;
  logic            rm_valid;
  logic [1:0][6:0] rm_addr;
  logic [1:0]      rm_hit, det, loss, cerr, bon, brst, rpin, p_out, p_oe, p_sense;
  logic [7:0]      ofs [7] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  int              n_errors = 0;
  int              n_tests = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  lcsr_far_model u_far (.clk(clock), .link_det(det), .link_loss(loss), .crc_err(cerr),
    .bist_on(bon), .bist_rst(brst), .rpin(rpin));

  lcsr_regs u_dut (.CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .SECOND_PORT_SELECT(sel), .CRC_ERR_RESET(crc_rst), .TMDS_CLK_DETECT(tmds),
    .LINK_DETECT(det), .LINK_LOSS(loss), .BACKCHAN_CRC_ERR(cerr), .BIST_ACTIVE(bon),
    .BIST_RESTART(brst), .I2C_ADDR_VALID(avalid), .I2C_ADDR(i2c_addr),
    .REMAP_VALID(rm_valid), .REMAP_PORT_HIT(rm_hit), .REMAP_ADDR(rm_addr),
    .REMOTE_PIN_VALUE(rpin), .PIN_ZERO_IN(pin_in), .PIN_ZERO_OUT(p_out),
    .PIN_ZERO_OE(p_oe), .PIN_ZERO_SENSE(p_sense));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strobes rise and fall on falling edges so the rising edge sees them settled
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clock);
    chk("read valid", 8'h01, {7'h00, rvalid});
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask : wr_reg

  task automatic remap(input logic [6:0] a, input logic [1:0] hit, input logic [6:0] ta);
    @(negedge clock);
    i2c_addr = a;
    avalid = 1'b1;
    @(negedge clock);
    avalid = 1'b0;
    chk("remap valid", 8'h01, {7'h00, rm_valid});
    chk("remap hit", {6'h00, hit}, {6'h00, rm_hit});
    chk("remap addr", {1'b0, ta}, {1'b0, rm_addr[hit[1]]});
  endtask : remap

  // With the pad driven the output is compared, otherwise the captured level
  task automatic pin_chk(input int p, input logic oe, input logic v);
    repeat (2) @(negedge clock);
    chk("pin oe", {7'h00, oe}, {7'h00, p_oe[p]});
    chk("pin level", {7'h00, v}, {7'h00, oe ? p_out[p] : p_sense[p]});
  endtask : pin_chk

  task automatic clr;
    crc_rst = 1'b1;
    @(negedge clock);
    crc_rst = 1'b0;
    repeat (2) @(negedge clock);
  endtask : clr

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Saturation alone needs about 66k cycles
  initial begin
    #1_000_000;
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
    $display("test reset values done");
    wr_reg(lcsr_pkg::OFS_TARGET, 8'h55);
    wr_reg(lcsr_pkg::OFS_ALIAS, 8'h67);
    rd_chk(lcsr_pkg::OFS_ALIAS, 8'h66);
    remap(7'h33, 2'h1, 7'h2A);
    remap(7'h34, 2'h0, 7'h34);
    wr_reg(lcsr_pkg::OFS_TARGET, 8'h00);
    remap(7'h33, 2'h0, 7'h33);
    sel = 1'b1;
    rd_chk(lcsr_pkg::OFS_ALIAS, 8'h00);
    wr_reg(lcsr_pkg::OFS_TARGET, 8'h55);
    sel = 1'b0;
    remap(7'h33, 2'h0, 7'h33);
    sel = 1'b1;
    wr_reg(lcsr_pkg::OFS_ALIAS, 8'h66);
    sel = 1'b0;
    remap(7'h33, 2'h2, 7'h2A);
    wr_reg(lcsr_pkg::OFS_CRC_LO, 8'hAA);
    rd_chk(lcsr_pkg::OFS_CRC_LO, 8'h00);
    $display("test remap done");
    tmds = 1'b1;
    u_far.link(0, 1'b1);
    u_far.errs(0, 3);
    rd_chk(lcsr_pkg::OFS_CRC_LO, 8'h03);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h07);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h07);
    rd_chk(lcsr_pkg::OFS_CRC_LO, 8'h03);
    sel = 1'b1;
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h04);
    sel = 1'b0;
    u_far.bist(0, 1'b1);
    u_far.errs(0, 1);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h0F);
    u_far.restart(0);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h07);
    u_far.errs(0, 1);
    u_far.bist(0, 1'b0);
    u_far.lose(0);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h14);
    u_far.link(0, 1'b1);
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h15);
    clr();
    rd_chk(lcsr_pkg::OFS_STATUS, 8'h05);
    rd_chk(lcsr_pkg::OFS_CRC_LO, 8'h00);
    u_far.errs(0, 65540);
    rd_chk(lcsr_pkg::OFS_CRC_LO, 8'hFF);
    rd_chk(lcsr_pkg::OFS_CRC_HI, 8'hFF);
    clr();
    rd_chk(lcsr_pkg::OFS_CRC_HI, 8'h00);
    $display("test status done");
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h09);
    pin_chk(0, 1'b1, 1'b1);
    rd_chk(lcsr_pkg::OFS_PIN0, 8'h09);
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h0A);
    pin_chk(0, 1'b0, 1'b0);
    pin_in[0] = 1'b1;
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h03);
    pin_chk(0, 1'b0, 1'b1);
    pin_in[0] = 1'b0;
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h04);
    pin_chk(0, 1'b0, 1'b0);
    u_far.remote(0, 1'b1);
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h05);
    pin_chk(0, 1'b1, 1'b1);
    u_far.lose(0);
    u_far.remote(0, 1'b0);
    pin_chk(0, 1'b1, 1'b1);
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h07);
    pin_chk(0, 1'b1, 1'b0);
    u_far.remote(0, 1'b1);
    u_far.link(0, 1'b1);
    pin_chk(0, 1'b1, 1'b1);
    sel = 1'b1;
    wr_reg(lcsr_pkg::OFS_PIN0, 8'h01);
    pin_chk(1, 1'b1, 1'b0);
    pin_chk(0, 1'b1, 1'b1);
    $display("test pins done");
    conclude();
  end
endmodule : test_lcsr_regs
